// ### src/pvcs_pkg.sv
// constants for the port configuration and secondary link status registers
package pvcs_pkg;
    // ------------------------------------------------------------
    // register map: printed offsets are indices, byte address is 4x
    // ------------------------------------------------------------
    localparam logic [7:0] PVCS_IDX_CFG = 8'h10;
    localparam logic [7:0] PVCS_IDX_STS = 8'h11;
    localparam logic [7:0] PVCS_ADDR_CFG = {PVCS_IDX_CFG[5:0], 2'b00};
    localparam logic [7:0] PVCS_ADDR_STS = {PVCS_IDX_STS[5:0], 2'b00};
    localparam logic [8:0] PVCS_CFG_RESET = 9'h080;
    localparam logic [8:0] PVCS_CFG_RSVD = 9'h05D;
    localparam logic [15:0] PVCS_STS_RESET = 16'h0000;
    // ------------------------------------------------------------
    // configuration field positions
    // ------------------------------------------------------------
    localparam int PVCS_CFG_ECHO_DIS = 8;
    localparam int PVCS_CFG_CRS_EXT = 7;
    localparam int PVCS_CFG_PRE_EN = 5;
    localparam int PVCS_CFG_ALT_NP = 1;
    localparam int PVCS_CFG_W = 9;
    // ------------------------------------------------------------
    // status field positions
    // ------------------------------------------------------------
    localparam int PVCS_STS_100 = 14;
    localparam int PVCS_STS_TX = 13;
    localparam int PVCS_STS_RX = 12;
    localparam int PVCS_STS_COL = 11;
    localparam int PVCS_STS_LINK = 10;
    localparam int PVCS_STS_FDX = 9;
    localparam int PVCS_STS_AN = 8;
    localparam int PVCS_STS_ANC = 7;
    localparam int PVCS_STS_POL = 5;
    localparam int PVCS_STS_PAUSE = 4;
    localparam int PVCS_STS_ERR = 3;
    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] PVCS_RESP_OKAY = 2'h0;
    localparam logic [1:0] PVCS_RESP_SLVERR = 2'h2;
endpackage : pvcs_pkg

// ### src/pvcs_rx_shaper.sv
// receive-side carrier and data-valid shaping under configuration control
`timescale 1ns/1ns
module pvcs_rx_shaper
    import pvcs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic speed_100,
    input wire logic crs_extend,
    input wire logic preamble_en,
    // raw receive path from the decoder
    input wire logic carrier_raw,
    input wire logic frame_valid_raw,
    input wire logic [3:0] rxd_raw,
    // shaped media-independent outputs
    output logic crs_q,
    output logic rx_dv_q,
    output logic [3:0] rxd_q
);
    // ------------------------------------------------------------
    // combinational shaping
    // ------------------------------------------------------------
    logic pre_mode;
    logic ext_on;
    logic rx_dv_d;
    logic crs_d;
    logic [3:0] rxd_d;

    // preamble forced on at 100 Mb/s whatever software chose
    assign pre_mode = speed_100 | preamble_en;
    // extension only meaningful at 10 Mb/s
    assign ext_on = crs_extend & ~speed_100;
    // data valid either from carrier (preamble) or from the delimiter
    assign rx_dv_d = frame_valid_raw | (pre_mode & carrier_raw);
    // with extension on at 10 Mb/s, carrier held while data valid stays up, so CRS never drops first once data valid has been high a cycle
    assign crs_d = carrier_raw | (ext_on & rx_dv_q & rx_dv_d);
    // data lines quiet whenever data valid is low
    assign rxd_d = rx_dv_d ? rxd_raw : 4'h0;

    // ------------------------------------------------------------
    // output flops
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            crs_q <= 1'b0;
            rx_dv_q <= 1'b0;
            rxd_q <= 4'h0;
        end else begin
            crs_q <= crs_d;
            rx_dv_q <= rx_dv_d;
            rxd_q <= rxd_d;
        end
    end
endmodule : pvcs_rx_shaper

// ### src/pvcs_regs.sv
// port configuration and secondary link status registers behind an AXI4-Lite slave
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module pvcs_regs
    import pvcs_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // link state from the transceiver core
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic link_up,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic collision,
    input wire logic autoneg_enabled,
    input wire logic autoneg_complete,
    input wire logic polarity_reversed,
    input wire logic pause_capable,
    // error sources and their clearing reads
    input wire logic remote_fault,
    input wire logic jabber_detect,
    input wire logic parallel_detect_fault,
    input wire logic error_source_read,
    // auto-negotiation advertisement
    input wire logic adv_alt_next_page,
    // raw receive path
    input wire logic carrier_raw,
    input wire logic frame_valid_raw,
    input wire logic [3:0] rxd_raw,
    // controls out to the transceiver core
    output logic tp_echo_enable,
    output logic alt_next_page_enable,
    // shaped media-independent receive outputs
    output logic crs,
    output logic rx_dv,
    output logic [3:0] rxd
);
    // ------------------------------------------------------------
    // write channel state
    // ------------------------------------------------------------
    logic aw_full_q;
    logic aw_full_d;
    logic w_full_q;
    logic w_full_d;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic awready_q;
    logic wready_q;
    logic bvalid_q;
    logic bvalid_d;
    logic [1:0] bresp_q;

    // handshakes and the write strobe into the register file
    logic aw_fire;
    logic w_fire;
    logic do_write;
    logic wr_cfg;
    logic wr_hit;
    logic aw_is_cfg;
    logic aw_is_sts;

    assign aw_fire = s_axi_awvalid & awready_q;
    assign w_fire = s_axi_wvalid & wready_q;
    // write executes once both halves are held and no answer is pending
    assign do_write = aw_full_q & w_full_q & ~bvalid_q;
    // word compare at full width; the two byte-lane bits never pick a register
    assign aw_is_cfg = {awaddr_q[ADDR_W-1:2], 2'b00} == ADDR_W'(PVCS_ADDR_CFG);
    assign aw_is_sts = {awaddr_q[ADDR_W-1:2], 2'b00} == ADDR_W'(PVCS_ADDR_STS);
    assign wr_cfg = do_write & aw_is_cfg;
    // status is read-only: a write there is accepted and discarded
    assign wr_hit = aw_is_cfg | aw_is_sts;
    assign aw_full_d = do_write ? 1'b0 : (aw_full_q | aw_fire);
    assign w_full_d = do_write ? 1'b0 : (w_full_q | w_fire);
    assign bvalid_d = do_write | (bvalid_q & ~s_axi_bready);

    // address and data are taken in either order and held until the write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= ~aw_full_d & ~bvalid_d;
            wready_q <= ~w_full_d & ~bvalid_d;
            bvalid_q <= bvalid_d;
        end
    end

    // payload captures, only meaningful while the full flags are set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bresp_q <= PVCS_RESP_OKAY;
        end else begin
            if (aw_fire) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                bresp_q <= wr_hit ? PVCS_RESP_OKAY : PVCS_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------
    logic [PVCS_CFG_W-1:0] cfg_q;
    logic [PVCS_CFG_W-1:0] cfg_d;
    logic [PVCS_CFG_W-1:0] cfg_wmask;

    // bits 7:0 ride lane 0, bit 8 rides lane 1
    assign cfg_wmask = {wstrb_q[1], {8{wstrb_q[0]}}};
    // reserved bits are stored as written; the master is expected to write zero
    assign cfg_d = (cfg_q & ~cfg_wmask) | (wdata_q[PVCS_CFG_W-1:0] & cfg_wmask);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_q <= PVCS_CFG_RESET;
        end else if (wr_cfg) begin
            cfg_q <= cfg_d;
        end
    end

    // ------------------------------------------------------------
    // error summary
    // ------------------------------------------------------------
    logic err_q;
    logic err_event;

    assign err_event = remote_fault | jabber_detect | parallel_detect_fault;

    // a new fault in the clearing cycle wins, so no event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 1'b0;
        end else if (err_event) begin
            err_q <= 1'b1;
        end else if (error_source_read) begin
            err_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // secondary status snapshot
    // ------------------------------------------------------------
    logic [15:0] sts_d;
    logic [15:0] sts_q;

    always_comb begin
        sts_d = PVCS_STS_RESET;
        sts_d[PVCS_STS_100] = speed_100;
        sts_d[PVCS_STS_TX] = tx_active;
        sts_d[PVCS_STS_RX] = rx_active;
        sts_d[PVCS_STS_COL] = collision;
        sts_d[PVCS_STS_LINK] = link_up;
        sts_d[PVCS_STS_FDX] = full_duplex;
        sts_d[PVCS_STS_AN] = autoneg_enabled;
        sts_d[PVCS_STS_ANC] = autoneg_complete;
        sts_d[PVCS_STS_POL] = polarity_reversed;
        sts_d[PVCS_STS_PAUSE] = pause_capable;
        sts_d[PVCS_STS_ERR] = err_q | err_event;
    end

    // one register stage keeps bus reads off the raw core nets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sts_q <= PVCS_STS_RESET;
        end else begin
            sts_q <= sts_d;
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------
    logic arready_q;
    logic rvalid_q;
    logic rvalid_d;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_fire;
    logic rd_cfg;
    logic rd_sts;
    logic [31:0] rd_mux;

    assign ar_fire = s_axi_arvalid & arready_q;
    assign rd_cfg = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(PVCS_ADDR_CFG);
    assign rd_sts = {s_axi_araddr[ADDR_W-1:2], 2'b00} == ADDR_W'(PVCS_ADDR_STS);
    // upper half and unmapped words read as zero
    assign rd_mux = rd_cfg ? 32'(cfg_q) : (rd_sts ? 32'(sts_q) : 32'h0000_0000);
    assign rvalid_d = ar_fire | (rvalid_q & ~s_axi_rready);

    // one read in flight; data answers the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= PVCS_RESP_OKAY;
        end else begin
            arready_q <= ~rvalid_d;
            rvalid_q <= rvalid_d;
            if (ar_fire) begin
                rdata_q <= rd_mux;
                rresp_q <= (rd_cfg | rd_sts) ? PVCS_RESP_OKAY : PVCS_RESP_SLVERR;
            end
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------
    // controls to the transceiver core
    // ------------------------------------------------------------
    logic echo_en_q;
    logic alt_np_q;
    logic echo_en_d;
    logic alt_np_d;

    // echo is only suppressed in 10 Mb/s half duplex; elsewhere it is normal
    assign echo_en_d = ~(cfg_q[PVCS_CFG_ECHO_DIS] & ~speed_100 & ~full_duplex);
    // the advertised capability has no effect unless software enables it here
    assign alt_np_d = cfg_q[PVCS_CFG_ALT_NP] & adv_alt_next_page;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            echo_en_q <= 1'b1;
            alt_np_q <= 1'b0;
        end else begin
            echo_en_q <= echo_en_d;
            alt_np_q <= alt_np_d;
        end
    end

    assign tp_echo_enable = echo_en_q;
    assign alt_next_page_enable = alt_np_q;

    // ------------------------------------------------------------
    // receive shaping
    // ------------------------------------------------------------
    pvcs_rx_shaper u_rx_shaper (
        .aclk(aclk),
        .aresetn(aresetn),
        .speed_100(speed_100),
        .crs_extend(cfg_q[PVCS_CFG_CRS_EXT]),
        .preamble_en(cfg_q[PVCS_CFG_PRE_EN]),
        .carrier_raw(carrier_raw),
        .frame_valid_raw(frame_valid_raw),
        .rxd_raw(rxd_raw),
        .crs_q(crs),
        .rx_dv_q(rx_dv),
        .rxd_q(rxd)
    );
endmodule : pvcs_regs

// ### testbench/pvcs_checker_assertions.sv
// concurrent checks on the shaped receive path and the config controls
`timescale 1ns/1ns
module pvcs_checker
    import pvcs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // causes
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic adv_alt_next_page,
    input wire logic carrier_raw,
    input wire logic frame_valid_raw,
    input wire logic [3:0] rxd_raw,
    // effects
    input wire logic tp_echo_enable,
    input wire logic alt_next_page_enable,
    input wire logic crs,
    input wire logic rx_dv,
    input wire logic [3:0] rxd
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // every output here is registered, so each effect lands one edge after its cause
    fast_preamble_a: assert property (speed_100 && carrier_raw |=> rx_dv)
        else $error("rx_dv low with carrier at 100 Mb/s");
    fast_data_a: assert property (speed_100 && carrier_raw |=> rxd == $past(rxd_raw))
        else $error("rxd not passed at 100 Mb/s");
    sfd_valid_a: assert property (frame_valid_raw |=> rx_dv && rxd == $past(rxd_raw))
        else $error("frame not delivered");
    idle_quiet_a: assert property (!carrier_raw && !frame_valid_raw |=> !rx_dv && rxd == 4'h0)
        else $error("rx path active while idle");
    carrier_crs_a: assert property (carrier_raw |=> crs)
        else $error("crs missing with carrier");
    crs_drop_a: assert property (!carrier_raw && (speed_100 || !frame_valid_raw) |=> !crs)
        else $error("crs held without cause");
    echo_on_a: assert property (full_duplex || speed_100 |=> tp_echo_enable)
        else $error("echo blocked outside 10 Mb/s half duplex");
    altnp_gate_a: assert property (!adv_alt_next_page |=> !alt_next_page_enable)
        else $error("alternate next page without advertisement");
endmodule : pvcs_checker

bind pvcs_regs pvcs_checker u_chk (.aclk, .aresetn, .speed_100, .full_duplex, .adv_alt_next_page,
    .carrier_raw, .frame_valid_raw, .rxd_raw, .tp_echo_enable, .alt_next_page_enable, .crs, .rx_dv, .rxd);

// ### testbench/pvcs_mgmt_master.sv
// management master model speaking the register bus
`timescale 1ns/1ns
module pvcs_mgmt_master
    import pvcs_pkg::*;
(
    // clock
    input wire logic aclk,
    // write side
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    // read side
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr} = 16'h0000;
        wdata = 32'h0;
        wstrb = 4'hF;
    end

    // one write; released payload is inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= dat & ~{23'h0, PVCS_CFG_RSVD};
        {awvalid, wvalid, bready} <= 3'h7;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~wdata;
            end
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    // one read; reserved bits are left for the caller to mask
    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (rvalid) begin
                dat = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd
endmodule : pvcs_mgmt_master

// ### testbench/pvcs_regs_tb.sv
// self-checking bench for the configuration and secondary status registers
`timescale 1ns/1ns
module pvcs_regs_tb
    import pvcs_pkg::*;
();
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb, rxr, rxd;
    logic [1:0] bresp, rresp, r;
    logic [9:0] lk;
    logic [2:0] ef;
    logic clr, adv, car, fv, echo, altnp, crs, rx_dv;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int pos[10] = '{PVCS_STS_100, PVCS_STS_FDX, PVCS_STS_LINK, PVCS_STS_TX, PVCS_STS_RX,
                    PVCS_STS_COL, PVCS_STS_AN, PVCS_STS_ANC, PVCS_STS_POL, PVCS_STS_PAUSE};

    pvcs_regs #(.ADDR_W(8)) DUT (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .speed_100(lk[0]), .full_duplex(lk[1]), .link_up(lk[2]),
        .tx_active(lk[3]), .rx_active(lk[4]), .collision(lk[5]), .autoneg_enabled(lk[6]),
        .autoneg_complete(lk[7]), .polarity_reversed(lk[8]), .pause_capable(lk[9]),
        .remote_fault(ef[0]), .jabber_detect(ef[1]), .parallel_detect_fault(ef[2]),
        .error_source_read(clr), .adv_alt_next_page(adv), .carrier_raw(car), .frame_valid_raw(fv),
        .rxd_raw(rxr), .tp_echo_enable(echo), .alt_next_page_enable(altnp), .crs, .rx_dv, .rxd);

    pvcs_mgmt_master mm (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic conclude();
        if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude

    // a hung handshake would otherwise stall the run forever
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    // move the raw receive inputs, then wait out the one-cycle shaping latency
    task automatic rx_step(input logic c, input logic f);
        @(posedge aclk);
        car <= c;
        fv <= f;
        repeat (2) @(posedge aclk);
    endtask : rx_step

    // reserved config bits are disregarded on read, so they are masked off
    task automatic t_defaults();
        mm.rd(PVCS_ADDR_CFG, d, r);
        chk("cfg reset", d & ~32'(PVCS_CFG_RSVD), 32'h080);
        chk("rd resp", 32'(r), 32'(PVCS_RESP_OKAY));
        chk("ctl reset", {30'h0, echo, altnp}, 32'h2);
    endtask : t_defaults

    // each core level alone must light exactly its own status bit
    task automatic t_status();
        for (int i = 0; i < 10; i++) begin
            @(posedge aclk);
            lk <= 10'h001 << i;
            repeat (2) @(posedge aclk);
            mm.rd(PVCS_ADDR_STS, d, r);
            chk("status bit", d, 32'h1 << pos[i]);
        end
        lk <= 10'h000;
    endtask : t_status

    // error is sticky through status reads and writes, cleared only by the source read
    task automatic t_error();
        for (int j = 0; j < 3; j++) begin
            @(posedge aclk);
            ef <= 3'h1 << j;
            @(posedge aclk);
            ef <= 3'h0;
            mm.rd(PVCS_ADDR_STS, d, r);
            chk("error set", d, 32'h1 << PVCS_STS_ERR);
            mm.wr(PVCS_ADDR_STS, 32'h0, r);
            mm.rd(PVCS_ADDR_STS, d, r);
            chk("error kept", d, 32'h1 << PVCS_STS_ERR);
            clr <= 1'b1;
            @(posedge aclk);
            clr <= 1'b0;
            mm.rd(PVCS_ADDR_STS, d, r);
            chk("error clear", d, 32'h0);
        end
    endtask : t_error

    task automatic t_controls();
        mm.wr(PVCS_ADDR_CFG, 32'h15D, r);
        chk("wr resp", 32'(r), 32'(PVCS_RESP_OKAY));
        repeat (3) @(posedge aclk);
        chk("echo off", 32'(echo), 32'h0);
        mm.rd(PVCS_ADDR_CFG, d, r);
        chk("cfg back", d & ~32'(PVCS_CFG_RSVD), 32'h100);
        lk <= 10'h002;
        repeat (3) @(posedge aclk);
        chk("echo fdx", 32'(echo), 32'h1);
        lk <= 10'h001;
        repeat (3) @(posedge aclk);
        chk("echo 100", 32'(echo), 32'h1);
        lk <= 10'h000;
        mm.wr(PVCS_ADDR_CFG, 32'h002, r);
        adv <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("altnp on", {30'h0, altnp, echo}, 32'h3);
        adv <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("altnp off", 32'(altnp), 32'h0);
    endtask : t_controls

    task automatic t_rx();
        rxr <= 4'h5;
        mm.wr(PVCS_ADDR_CFG, 32'h080, r);
        rx_step(1'b1, 1'b0);
        chk("pre off", {26'h0, crs, rx_dv, rxd}, 32'h20);
        rx_step(1'b1, 1'b1);
        chk("sfd", {27'h0, rx_dv, rxd}, 32'h15);
        rx_step(1'b0, 1'b1);
        chk("crs ext", 32'(crs), 32'h1);
        rx_step(1'b0, 1'b0);
        chk("crs end", 32'(crs), 32'h0);
        mm.wr(PVCS_ADDR_CFG, 32'h020, r);
        rx_step(1'b1, 1'b0);
        chk("pre on", {27'h0, rx_dv, rxd}, 32'h15);
        rx_step(1'b0, 1'b1);
        chk("crs plain", 32'(crs), 32'h0);
        mm.wr(PVCS_ADDR_CFG, 32'h000, r);
        lk <= 10'h001;
        rx_step(1'b1, 1'b0);
        chk("pre 100", {27'h0, rx_dv, rxd}, 32'h15);
        rx_step(1'b0, 1'b0);
        lk <= 10'h000;
    endtask : t_rx

    task automatic t_unmapped();
        mm.wr(8'h48, 32'h1, r);
        chk("wr unmapped", 32'(r), 32'(PVCS_RESP_SLVERR));
        mm.rd(8'h48, d, r);
        chk("rd unmapped", {d[29:0], r}, 32'h2);
    endtask : t_unmapped

    // reset, then the scenarios in turn
    initial begin
        aresetn = 1'b0;
        {lk, ef, clr, adv, car, fv, rxr} = 21'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_defaults();
        t_status();
        t_error();
        t_controls();
        t_rx();
        t_unmapped();
        conclude();
    end
endmodule : pvcs_regs_tb
